// ===== logic/roc_output_control.sv
// Ring oscillator output control: post-scaler, phase output, status, entropy bit and down counter.
`timescale 1ns/1ns

module roc_output_control
    import roc_pkg::*;
(
    // Clock and reset
    input  wire logic                i_clock,
    input  wire logic                i_srst,
    // Register port
    input  wire logic [ADDR_W-1:0]   i_addr,
    input  wire logic [31:0]         i_wdata,
    input  wire logic                i_wr,
    input  wire logic                i_rd,
    output logic      [31:0]         o_rdata,
    // Analog oscillator side
    input  wire logic                i_osc_level,
    input  wire logic                i_osc_stable,
    output logic                     o_osc_enable,
    output logic      [11:0]         o_osc_range,
    output logic      [23:0]         o_stage_strength,
    output logic                     o_osc_pause,
    // Divided clock outputs and interrupt
    output logic                     o_main_clock,
    output logic                     o_phase_clock,
    output logic                     o_irq
);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [2:0]       osc_sync;
    logic [2:0]       stable_sync;
    logic             osc_lvl;
    logic             osc_rise;
    logic             stable_lvl;

    // Three stages; a level is accepted only when the second and third agree.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            osc_sync    <= 3'h7;
            stable_sync <= 3'h0;
        end else begin
            osc_sync    <= {osc_sync[1:0], i_osc_level};
            stable_sync <= {stable_sync[1:0], i_osc_stable};
        end
    end

    // Filtered levels; the entropy bit reads one after reset.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            osc_lvl    <= 1'b1;
            stable_lvl <= 1'b0;
        end else begin
            if (osc_sync[1] == osc_sync[2]) begin
                osc_lvl <= osc_sync[2];
            end
            if (stable_sync[1] == stable_sync[2]) begin
                stable_lvl <= stable_sync[2];
            end
        end
    end

    assign osc_rise = (osc_sync[1] == osc_sync[2]) && osc_sync[2] && !osc_lvl;

    // ************************************************************
    // Write decode
    // ************************************************************
    logic             wr_ctrl;
    logic             wr_str_low;
    logic             wr_str_high;
    logic             wr_pause;
    logic             wr_post;
    logic             wr_phase;
    logic             wr_status;
    logic             wr_count;
    logic             wr_irq_stat;
    logic             wr_irq_mask;
    logic [11:0]      post_offset;
    logic             bad_ctrl;
    logic             bad_write;

    assign wr_ctrl     = i_wr && (i_addr == OFS_OSC_CTRL);
    assign wr_str_low  = i_wr && (i_addr == OFS_STR_LOW);
    assign wr_str_high = i_wr && (i_addr == OFS_STR_HIGH);
    assign wr_pause    = i_wr && (i_addr == OFS_PAUSE);
    assign wr_post     = i_wr && (i_addr == OFS_POST_SCALER);
    assign wr_phase    = i_wr && (i_addr == OFS_PHASE_CTRL);
    assign wr_status   = i_wr && (i_addr == OFS_STATUS);
    assign wr_count    = i_wr && (i_addr == OFS_DOWN_COUNT);
    assign wr_irq_stat = i_wr && (i_addr == OFS_IRQ_STATUS);
    assign wr_irq_mask = i_wr && (i_addr == OFS_IRQ_MASK);
    assign post_offset = i_wdata[11:0] - POST_KEY;

    // Any coded field outside its legal set counts as an invalid write.
    always_comb begin
        bad_ctrl = 1'b0;
        if (wr_ctrl) begin
            if ((i_wdata[CTRL_EN_LSB +: 12] != OSC_DISABLE) && (i_wdata[CTRL_EN_LSB +: 12] != OSC_ENABLE)) begin
                bad_ctrl = 1'b1;
            end
            if ((i_wdata[11:0] != RANGE_LOW) && (i_wdata[11:0] != RANGE_MEDIUM) &&
                (i_wdata[11:0] != RANGE_HIGH) && (i_wdata[11:0] != RANGE_TOOHIGH)) begin
                bad_ctrl = 1'b1;
            end
        end
    end

    assign bad_write = bad_ctrl
        || ((wr_str_low || wr_str_high) && (i_wdata[STR_KEY_LSB +: 16] != STRENGTH_KEY))
        || (wr_pause && (i_wdata != PAUSE_CODE) && (i_wdata != RUN_CODE))
        || (wr_post && (post_offset > POST_MAX_OFFSET))
        || (wr_phase && (i_wdata[PH_KEY_LSB +: 8] != PHASE_KEY));

    // ************************************************************
    // Oscillator configuration registers
    // ************************************************************
    // A wrong enable code still enables: stopping the ring by accident would hang the chip.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_osc_enable <= 1'b1;
            o_osc_range  <= RANGE_RESET;
        end else if (wr_ctrl) begin
            o_osc_enable <= (i_wdata[CTRL_EN_LSB +: 12] != OSC_DISABLE);
            o_osc_range  <= i_wdata[11:0];
        end
    end

    // Drive strengths: a wrong key clears all four stages of that register.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_stage_strength <= 24'h000000;
        end else if (wr_str_low || wr_str_high) begin
            for (int s = 0; s < 4; s++) begin
                if (i_wdata[STR_KEY_LSB +: 16] == STRENGTH_KEY) begin
                    o_stage_strength[(wr_str_high ? 12 : 0) + s*3 +: 3] <= i_wdata[s*4 +: 3];
                end else begin
                    o_stage_strength[(wr_str_high ? 12 : 0) + s*3 +: 3] <= 3'h0;
                end
            end
        end
    end

    // Only the exact pause code pauses; everything else runs.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_osc_pause <= 1'b0;
        end else if (wr_pause) begin
            o_osc_pause <= (i_wdata == PAUSE_CODE);
        end
    end

    // ************************************************************
    // Post-scaler and phase settings (software side)
    // ************************************************************
    logic [5:0]       req_ratio;
    logic [7:0]       phase_key;
    logic             req_en;
    logic             req_flip;
    logic [1:0]       req_shift;

    // Ratio decode from key plus offset.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            req_ratio <= RATIO_RESET;
        end else if (wr_post) begin
            if (post_offset > POST_MAX_OFFSET) begin
                req_ratio <= RATIO_FALLBACK;
            end else if (post_offset == 12'h000) begin
                req_ratio <= RATIO_OF_ZERO;
            end else begin
                req_ratio <= post_offset[5:0];
            end
        end
    end

    // Phase control; a wrong key forces an enabled, unshifted output.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            phase_key <= 8'h00;
            req_en    <= 1'b1;
            req_flip  <= 1'b0;
            req_shift <= 2'h0;
        end else if (wr_phase) begin
            phase_key <= i_wdata[PH_KEY_LSB +: 8];
            req_flip  <= i_wdata[PH_FLIP_BIT];
            if (i_wdata[PH_KEY_LSB +: 8] == PHASE_KEY) begin
                req_en    <= i_wdata[PH_EN_BIT];
                req_shift <= i_wdata[1:0];
            end else begin
                req_en    <= 1'b1;
                req_shift <= 2'h0;
            end
        end
    end

    // ************************************************************
    // Divider running on oscillator edges
    // ************************************************************
    logic [5:0]       act_ratio;
    logic             act_en;
    logic             act_flip;
    logic [1:0]       act_shift;
    logic [4:0]       div_cnt;
    logic [2:0]       main_hist;
    logic             main_level;
    logic             phase_level;
    logic             wrap;

    assign wrap       = (div_cnt == 5'(act_ratio - RATIO_ONE));
    assign main_level = (act_ratio == RATIO_ONE) ? osc_lvl : ({1'b0, div_cnt} < (act_ratio >> 1));
    assign phase_level = (act_shift == 2'h0) ? main_level : main_hist[act_shift - 2'h1];

    // New settings are taken only at the end of a period, so no runt pulse appears.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            div_cnt   <= 5'h00;
            act_ratio <= RATIO_RESET;
            act_en    <= 1'b1;
            act_flip  <= 1'b0;
            act_shift <= 2'h0;
        end else if (osc_rise) begin
            if (wrap) begin
                div_cnt   <= 5'h00;
                act_ratio <= req_ratio;
                act_en    <= req_en;
                act_flip  <= req_flip;
                act_shift <= req_shift;
            end else begin
                div_cnt <= div_cnt + 5'h01;
            end
        end
    end

    // Delay line of the main level, one stage per oscillator clock.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            main_hist <= 3'h0;
        end else if (osc_rise) begin
            main_hist <= {main_hist[1:0], main_level};
        end
    end

    // Registered clock outputs; the inversion has no meaning at ratio one.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_main_clock  <= 1'b0;
            o_phase_clock <= 1'b0;
        end else begin
            o_main_clock  <= main_level;
            o_phase_clock <= act_en && (phase_level ^ (act_flip && (act_ratio != RATIO_ONE)));
        end
    end

    // ************************************************************
    // Status and down counter
    // ************************************************************
    logic             st_enabled;
    logic             st_running;
    logic             st_stable;
    logic             st_bad;
    logic [7:0]       down_count;
    logic             count_done;

    // Status levels start at zero and follow the oscillator a cycle after reset.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            st_enabled <= 1'b0;
            st_running <= 1'b0;
            st_stable  <= 1'b0;
        end else begin
            st_enabled <= o_osc_enable;
            st_running <= o_osc_enable && !o_osc_pause;
            st_stable  <= o_osc_enable && !o_osc_pause && stable_lvl;
        end
    end

    // Invalid-write flag: write one to clear, a new invalid write wins.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            st_bad <= 1'b0;
        end else if (bad_write) begin
            st_bad <= 1'b1;
        end else if (wr_status && i_wdata[ST_BAD_BIT]) begin
            st_bad <= 1'b0;
        end
    end

    assign count_done = osc_rise && (down_count == 8'h01) && !wr_count;

    // Down counter: a write always loads, even in the cycle of an oscillator edge.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            down_count <= 8'h00;
        end else if (wr_count) begin
            down_count <= i_wdata[7:0];
        end else if (osc_rise && (down_count != 8'h00)) begin
            down_count <= down_count - 8'h01;
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_set;
    logic             stable_prev;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            stable_prev <= 1'b0;
        end else begin
            stable_prev <= st_stable;
        end
    end

    always_comb begin
        irq_set                 = '0;
        irq_set[IRQ_BAD]        = bad_write;
        irq_set[IRQ_COUNT_DONE] = count_done;
        irq_set[IRQ_STABLE]     = st_stable && !stable_prev;
    end

    // Sticky bits; a set in the cycle of its clear is kept.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            irq_stat <= '0;
            irq_mask <= '0;
        end else begin
            irq_stat <= (irq_stat & ~(wr_irq_stat ? i_wdata[IRQ_W-1:0] : '0)) | irq_set;
            if (wr_irq_mask) begin
                irq_mask <= i_wdata[IRQ_W-1:0];
            end
        end
    end

    assign o_irq = |(irq_stat & irq_mask);

    // ************************************************************
    // Read back
    // ************************************************************
    logic [31:0]      rd_value;

    // Reserved bits read zero; unmapped offsets read zero.
    always_comb begin
        rd_value = 32'h00000000;
        case (i_addr)
            OFS_OSC_CTRL: begin
                rd_value[CTRL_EN_LSB +: 12] = o_osc_enable ? OSC_ENABLE : OSC_DISABLE;
                rd_value[11:0]              = o_osc_range;
            end
            OFS_STR_LOW: begin
                for (int s = 0; s < 4; s++) rd_value[s*4 +: 3] = o_stage_strength[s*3 +: 3];
            end
            OFS_STR_HIGH: begin
                for (int s = 0; s < 4; s++) rd_value[s*4 +: 3] = o_stage_strength[12 + s*3 +: 3];
            end
            OFS_PAUSE:       rd_value = o_osc_pause ? PAUSE_CODE : RUN_CODE;
            OFS_POST_SCALER: rd_value[11:0] = POST_KEY + {7'h00, req_ratio[4:0]};
            OFS_PHASE_CTRL:  rd_value[11:0] = {phase_key, req_en, req_flip, req_shift};
            OFS_STATUS: begin
                rd_value[ST_STABLE_BIT] = st_stable;
                rd_value[ST_BAD_BIT]    = st_bad;
                rd_value[ST_RUN_BIT]    = st_running;
                rd_value[ST_EN_BIT]     = st_enabled;
            end
            OFS_ENTROPY:     rd_value[0] = osc_lvl;
            OFS_DOWN_COUNT:  rd_value[7:0] = down_count;
            OFS_IRQ_STATUS:  rd_value[IRQ_W-1:0] = irq_stat;
            OFS_IRQ_MASK:    rd_value[IRQ_W-1:0] = irq_mask;
            default:         rd_value = 32'h00000000;
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_rdata <= 32'h00000000;
        end else begin
            o_rdata <= i_rd ? rd_value : 32'h00000000;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);

    sequence post_write_in_range;
        wr_post && (post_offset != 12'h000) && (post_offset <= POST_MAX_OFFSET);
    endsequence

    sequence post_write_out_of_range;
        wr_post && (post_offset > POST_MAX_OFFSET);
    endsequence

    post_ratio_a: assert property (post_write_in_range |=> req_ratio == $past(post_offset[5:0]))
        else $error("post-scaler ratio not taken from write");
    post_fallback_a: assert property (post_write_out_of_range |=> req_ratio == RATIO_FALLBACK && st_bad)
        else $error("out of range post-scaler write not forced to 31");
    reset_ratio_a: assert property ($fell(i_srst) |-> req_ratio == RATIO_RESET && act_ratio == RATIO_RESET)
        else $error("post-scaler ratio not sixteen after reset");
    phase_key_a: assert property (wr_phase && i_wdata[PH_KEY_LSB +: 8] != PHASE_KEY |=> req_en && req_shift == 2'h0)
        else $error("wrong phase key did not force enabled unshifted output");
    flip_ignored_a: assert property (act_ratio == RATIO_ONE && act_shift == 2'h0 && act_en && !osc_rise
                                     |=> o_phase_clock == $past(osc_lvl))
        else $error("phase output inverted at ratio one");
    stable_enabled_a: assert property (st_stable |-> st_enabled && st_running)
        else $error("stable reported while oscillator not running");
    count_step_a: assert property (osc_rise && !wr_count && down_count != 8'h00
                                   |=> down_count == $past(down_count) - 8'h01)
        else $error("down counter did not step on oscillator edge");
    count_hold_a: assert property (down_count == 8'h00 && !wr_count |=> down_count == 8'h00)
        else $error("down counter moved past zero");
    entropy_read_a: assert property (i_rd && i_addr == OFS_ENTROPY |=> o_rdata[0] == $past(osc_lvl))
        else $error("entropy bit does not follow oscillator level");
    bad_sticky_a: assert property (bad_write ##1 !(wr_status && i_wdata[ST_BAD_BIT]) [*2] |-> st_bad)
        else $error("invalid-write flag lost without a clear");
    enable_code_a: assert property (wr_ctrl |=> o_osc_enable == ($past(i_wdata[CTRL_EN_LSB +: 12]) != OSC_DISABLE))
        else $error("enable code decoded wrongly");

endmodule : roc_output_control

// ===== logic/roc_pkg.sv
// Package of register map, key codes and field positions for the ring oscillator output control.
package roc_pkg;

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFS_OSC_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_STR_LOW     = 8'h04;
    localparam logic [7:0]  OFS_STR_HIGH    = 8'h08;
    localparam logic [7:0]  OFS_PAUSE       = 8'h0c;
    localparam logic [7:0]  OFS_POST_SCALER = 8'h10;
    localparam logic [7:0]  OFS_PHASE_CTRL  = 8'h14;
    localparam logic [7:0]  OFS_STATUS      = 8'h18;
    localparam logic [7:0]  OFS_ENTROPY     = 8'h1c;
    localparam logic [7:0]  OFS_DOWN_COUNT  = 8'h20;
    localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h24;
    localparam logic [7:0]  OFS_IRQ_MASK    = 8'h28;

    // ************************************************************
    // Oscillator control codes
    // ************************************************************
    localparam logic [11:0] OSC_DISABLE     = 12'hd1e;
    localparam logic [11:0] OSC_ENABLE      = 12'hfab;
    localparam logic [11:0] RANGE_LOW       = 12'hfa4;
    localparam logic [11:0] RANGE_MEDIUM    = 12'hfa5;
    localparam logic [11:0] RANGE_HIGH      = 12'hfa7;
    localparam logic [11:0] RANGE_TOOHIGH   = 12'hfa6;
    localparam logic [11:0] RANGE_RESET     = 12'haa0;
    localparam int          CTRL_EN_LSB     = 12;
    localparam logic [15:0] STRENGTH_KEY    = 16'h9696;
    localparam int          STR_KEY_LSB     = 16;
    localparam logic [31:0] PAUSE_CODE      = 32'h636f6d61;
    localparam logic [31:0] RUN_CODE        = 32'h77616b65;

    // ************************************************************
    // Post-scaler and phase control
    // ************************************************************
    localparam logic [11:0] POST_KEY        = 12'haa0;
    localparam logic [11:0] POST_MAX_OFFSET = 12'h01f;
    localparam logic [5:0]  RATIO_OF_ZERO   = 6'h20;
    localparam logic [5:0]  RATIO_FALLBACK  = 6'h1f;
    localparam logic [5:0]  RATIO_RESET     = 6'h10;
    localparam logic [5:0]  RATIO_ONE       = 6'h01;
    localparam logic [7:0]  PHASE_KEY       = 8'haa;
    localparam int          PH_KEY_LSB      = 4;
    localparam int          PH_EN_BIT       = 3;
    localparam int          PH_FLIP_BIT     = 2;

    // ************************************************************
    // Status and interrupt bit positions
    // ************************************************************
    localparam int          ST_STABLE_BIT   = 31;
    localparam int          ST_BAD_BIT      = 24;
    localparam int          ST_RUN_BIT      = 16;
    localparam int          ST_EN_BIT       = 12;
    localparam int          IRQ_W           = 3;
    localparam int          IRQ_BAD         = 0;
    localparam int          IRQ_COUNT_DONE  = 1;
    localparam int          IRQ_STABLE      = 2;

endpackage : roc_pkg

// ===== verif/test_ring_osc_output_control.sv
// Self-checking testbench for the ring oscillator output control block.
`timescale 1ns/1ns
module test_ring_osc_output_control;
    import roc_pkg::*;
    logic              i_clock, i_srst, i_wr, i_rd, i_osc_stable, osc_run;
    logic              i_osc_level = 1'b1;
    logic [ADDR_W-1:0] i_addr;
    logic [31:0]       i_wdata, o_rdata;
    logic [11:0]       o_osc_range;
    logic [23:0]       o_stage_strength;
    logic [1:0]        osc_div = 2'h0;
    logic              o_osc_enable, o_osc_pause, o_main_clock, o_phase_clock, o_irq;
    int                errors, checks_done, n;
    // Oscillator period is eight clocks, so a ratio r gives a period of 8r clocks.
    logic [31:0]       code [4] = '{32'haa2, 32'haa3, 32'haa0, 32'haa1};
    int                per [4] = '{16, 24, 256, 8};

    roc_output_control dut_u (.i_clock(i_clock), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_osc_level(i_osc_level), .i_osc_stable(i_osc_stable),
        .o_osc_enable(o_osc_enable), .o_osc_range(o_osc_range), .o_stage_strength(o_stage_strength),
        .o_osc_pause(o_osc_pause), .o_main_clock(o_main_clock), .o_phase_clock(o_phase_clock), .o_irq(o_irq));

    // System clock.
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    // Oscillator stand-in; four clocks a level, above the two the input filter needs.
    always @(posedge i_clock) begin
        osc_div <= osc_div + 2'h1;
        if (osc_run && osc_div == 2'h3) begin
            i_osc_level <= ~i_osc_level;
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Ends just past the edge, so a following strobe is never assigned twice in one time step.
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr    <= 1'b0;
        #1;
    endtask : reg_wr
    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd   <= 1'b0;
        #1;
        check(what, o_rdata, exp);
    endtask : rd_chk
    // Returns the clocks since entry up to the next main clock rise; bounded.
    task automatic rise_wait(output int c);
        logic last;
        last = o_main_clock;
        for (c = 1; c < 600; c++) begin
            @(posedge i_clock);
            #1;
            if (o_main_clock === 1'b1 && last === 1'b0) return;
            last = o_main_clock;
        end
        errors++;
        conclude();
    endtask : rise_wait
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude
    // Main sequence.
    initial begin
        i_srst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = '0;
        i_wdata = '0;
        i_osc_stable = 1'b0;
        osc_run = 1'b0;
        repeat (10) @(posedge i_clock);
        i_srst <= 1'b0;
        @(posedge i_clock);
        rd_chk("post", OFS_POST_SCALER, 32'h0ab0);
        rd_chk("phase", OFS_PHASE_CTRL, 32'h0008);
        rd_chk("status", OFS_STATUS, 32'h0001_1000);
        rd_chk("entropy", OFS_ENTROPY, 32'h1);
        rd_chk("count", OFS_DOWN_COUNT, 32'h0);
        rd_chk("unmapped", 8'h3c, 32'h0);
        reg_wr(OFS_POST_SCALER, 32'hffff_f123);
        rd_chk("post", OFS_POST_SCALER, 32'h0abf);
        rd_chk("status", OFS_STATUS, 32'h0101_1000);
        reg_wr(OFS_STATUS, 32'h0100_0000);
        rd_chk("status", OFS_STATUS, 32'h0001_1000);
        osc_run <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            // The shift field is still zero when ratio one is written last.
            reg_wr(OFS_POST_SCALER, code[i]);
            rd_chk("post", OFS_POST_SCALER, code[i]);
            repeat (3) rise_wait(n);
            check("period", n, per[i]);
            check("phase", o_phase_clock, o_main_clock);
        end
        reg_wr(OFS_PHASE_CTRL, 32'h0aac);
        repeat (3) rise_wait(n);
        check("flip", o_phase_clock, o_main_clock);
        reg_wr(OFS_POST_SCALER, 32'h0aa2);
        repeat (3) rise_wait(n);
        check("flip", o_phase_clock, {31'h0, ~o_main_clock});
        // Ratio four keeps main high sixteen clocks; a one-edge shift lags it by eight.
        reg_wr(OFS_PHASE_CTRL, 32'h0aa9);
        reg_wr(OFS_POST_SCALER, 32'h0aa4);
        repeat (3) rise_wait(n);
        repeat (4) @(posedge i_clock);
        check("shift", o_phase_clock, 32'h0);
        repeat (8) @(posedge i_clock);
        check("shift", o_phase_clock, 32'h1);
        reg_wr(OFS_IRQ_MASK, 32'h1);
        reg_wr(OFS_PHASE_CTRL, 32'h00ff);
        rd_chk("phase", OFS_PHASE_CTRL, 32'h00fc);
        check("irq", o_irq, 32'h1);
        reg_wr(OFS_IRQ_STATUS, 32'h1);
        #1;
        check("irq", o_irq, 32'h0);
        reg_wr(OFS_DOWN_COUNT, 32'h5);
        repeat (60) @(posedge i_clock);
        rd_chk("count", OFS_DOWN_COUNT, 32'h0);
        rd_chk("irq_status", OFS_IRQ_STATUS, 32'h2);
        i_osc_stable <= 1'b1;
        repeat (8) @(posedge i_clock);
        rd_chk("status", OFS_STATUS, 32'h8101_1000);
        // Enable, strength and pause codes; an invalid enable code must still enable.
        reg_wr(OFS_IRQ_STATUS, 32'h7);
        reg_wr(OFS_OSC_CTRL, 32'h0012_3fa7);
        check("enable", o_osc_enable, 32'h1);
        rd_chk("irq_status", OFS_IRQ_STATUS, 32'h1);
        reg_wr(OFS_OSC_CTRL, 32'h00d1_efa5);
        check("enable", o_osc_enable, 32'h0);
        check("range", o_osc_range, 32'hfa5);
        rd_chk("ctrl", OFS_OSC_CTRL, 32'h00d1_efa5);
        reg_wr(OFS_STR_HIGH, 32'h9696_7654);
        check("strength", o_stage_strength, 32'h00fa_c000);
        rd_chk("strength", OFS_STR_HIGH, 32'h7654);
        reg_wr(OFS_STR_HIGH, 32'h1234_7654);
        check("strength", o_stage_strength, 32'h0);
        reg_wr(OFS_PAUSE, 32'h636f_6d61);
        check("pause", o_osc_pause, 32'h1);
        reg_wr(OFS_PAUSE, 32'h0000_0001);
        check("pause", o_osc_pause, 32'h0);
        rd_chk("pause", OFS_PAUSE, 32'h7761_6b65);
        conclude();
    end
endmodule : test_ring_osc_output_control
